// ---- hw/code_address_pkg.sv ----
package code_address_pkg;

	// Register byte addresses on the bus
	localparam logic [3:0] code_segment_offset            = 4'h0;
	localparam logic [3:0] core_configuration_one_offset  = 4'h4;
	localparam logic [3:0] core_status_offset             = 4'h8;

	// Reset values
	localparam logic [15:0] code_segment_reset            = 16'h0000;
	localparam logic [15:0] core_configuration_one_reset  = 16'h0000;
	localparam logic [15:0] instruction_offset_reset      = 16'h0000;

	// Field positions in core_configuration_one
	localparam int zero_cycle_jump_bit               = 0;
	localparam int branch_prediction_bit             = 1;
	localparam int context_switch_bit                = 2;
	localparam int segmentation_off_bit              = 3;
	localparam int watchdog_control_bit              = 4;
	localparam int vector_spacing_low                = 5;
	localparam int vector_spacing_high               = 6;
	localparam logic [15:0] core_configuration_one_mask = 16'h007F;

	// AXI responses
	localparam logic [1:0] resp_okay   = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	// Instruction events from the execute pipeline
	typedef enum logic [2:0]
	{
		flow_none      = 3'b000,
		flow_sequence  = 3'b001,
		flow_near      = 3'b010,
		flow_far_jump  = 3'b011,
		flow_far_call  = 3'b100,
		flow_far_ret   = 3'b101,
		flow_int_ret   = 3'b110,
		flow_vector    = 3'b111
	} flow_kind_type;

	typedef struct packed
	{
		flow_kind_type kind;
		logic [7:0]    segment;
		logic [15:0]   offset;
	} flow_event_type;

	typedef struct packed
	{
		logic       zero_cycle_jump_enable;
		logic       branch_prediction_enable;
		logic       context_switch_interruptible;
		logic       watchdog_instructions_live;
		logic [4:0] vector_spacing_words;
	} core_controls_type;

endpackage

// ---- hw/code_address.sv ----
`timescale 1ns/1ns

// Operation
// RULE1 - Fetch address is segment byte over offset
// RULE2 - Offset register is not bus visible
// RULE3 - Offset updates on branches and fetches
// RULE4 - Offset word aligned, bit zero zero
// RULE5 - Segment in low byte, upper reads zero
// RULE6 - Segment readable, bus writes ignored
// RULE7 - Reset loads segment from vector segment
// RULE8 - Config bit3 selects mode, reset segmented
// RULE9 - Segmented: far flow loads segment
// RULE10 - Segmented: interrupt or trap loads vector segment
// RULE11 - Non-segmented: far flow leaves segment frozen
// RULE12 - Non-segmented: vectors still load vector segment
// RULE13 - Software keeps vector table in current segment
// RULE14 - Bits 6:5 set vector spacing 2..16
// RULE15 - Bit4 gates watchdog instruction execution
// RULE16 - Blocked watchdog instructions become no-ops
// RULE17 - Bit2 makes context switch interruptible
// RULE18 - Bit1 enables branch prediction
// RULE19 - Bit0 enables zero cycle jump
// RULE20 - Config writable only before end of initialisation
module code_address
	import code_address_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              clock_enable,
	// Vector segment value from interrupt logic
	input  wire logic [7:0]        vector_segment,
	// Execute pipeline
	input  wire flow_event_type    flow_event,
	input  wire logic              end_of_initialisation,
	input  wire logic              watchdog_disable_instruction,
	input  wire logic              watchdog_enable_instruction,
	// Toward fetch path and pipeline
	output logic [23:0]            fetch_address,
	output core_controls_type      core_controls,
	output logic                   watchdog_disable_execute,
	output logic                   watchdog_enable_execute,
	output logic                   segmentation_off,
	// AXI4-Lite write address
	input  wire logic [3:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [3:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	function automatic logic [4:0] spacing_words(input logic [1:0] code);
		spacing_words = 5'h02 << code;
	endfunction

	// Address decode shared by the write and read paths
	function automatic logic register_hit(input logic [3:0] addr);
		register_hit = (addr == code_segment_offset) || (addr == core_configuration_one_offset)
		            || (addr == core_status_offset);
	endfunction

	logic [7:0]  code_segment_pointer;
	logic [15:0] instruction_offset;
	logic [15:0] core_configuration_one;
	logic        supervisor;
	logic        reset_seen;
	logic [3:0]  aw_addr;
	logic        aw_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_held;

	wire logic segmented = ~core_configuration_one[segmentation_off_bit];  // [RULE8]
	wire logic is_far    = (flow_event.kind == flow_far_jump) || (flow_event.kind == flow_far_call)
	                    || (flow_event.kind == flow_far_ret)  || (flow_event.kind == flow_int_ret);
	wire logic is_vector = (flow_event.kind == flow_vector);
	wire logic watchdog_live = core_configuration_one[watchdog_control_bit] | supervisor;  // [RULE15]

	// Vector entry loads segment in either mode; far flow only while segmented
	wire logic load_vector_segment = is_vector;                          // [RULE10] [RULE12]
	wire logic load_far_segment    = is_far && segmented;                // [RULE9] [RULE11]
	wire logic [7:0] next_segment =
		load_vector_segment ? vector_segment :
		load_far_segment    ? flow_event.segment :
		                      code_segment_pointer;

	// Offset holds, steps one word, or takes the target with bit zero cleared
	wire logic        offset_hold    = (flow_event.kind == flow_none);
	wire logic        offset_step    = (flow_event.kind == flow_sequence);
	wire logic [15:0] offset_stepped = instruction_offset + 16'h0002;     // [RULE3]
	wire logic [15:0] offset_target  = {flow_event.offset[15:1], 1'b0};    // [RULE4]
	wire logic [15:0] next_offset =
		offset_hold ? instruction_offset :
		offset_step ? offset_stepped :
		              offset_target;  // [RULE3]
	wire logic [23:0] next_fetch_address = {next_segment, next_offset[15:1], 1'b0};  // [RULE1] [RULE4]

	// Enable needs the control bit; before end of init it is still a no-op without it
	wire logic next_disable_execute = watchdog_disable_instruction && watchdog_live;  // [RULE15] [RULE16]
	wire logic next_enable_execute  =
		watchdog_enable_instruction && core_configuration_one[watchdog_control_bit];  // [RULE16]

	// Pipeline controls follow the configuration one cycle later
	wire core_controls_type next_controls = '{
		zero_cycle_jump_enable:       core_configuration_one[zero_cycle_jump_bit],    // [RULE19]
		branch_prediction_enable:     core_configuration_one[branch_prediction_bit],  // [RULE18]
		context_switch_interruptible: core_configuration_one[context_switch_bit],     // [RULE17]
		watchdog_instructions_live:   watchdog_live,
		vector_spacing_words:
			spacing_words(core_configuration_one[vector_spacing_high:vector_spacing_low])  // [RULE14]
	};

	// Bus side
	wire logic write_go   = aw_held && w_held && !s_axi_bvalid;
	wire logic write_cfg  = write_go && (aw_addr == core_configuration_one_offset);
	wire logic write_hit  = register_hit(aw_addr);
	wire logic [15:0] strobe_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
	wire logic [15:0] next_config =
		((core_configuration_one & ~strobe_mask) | (w_data[15:0] & strobe_mask)) & core_configuration_one_mask;
	wire logic read_go    = s_axi_arvalid && !s_axi_rvalid;
	// Offset register deliberately has no read path
	wire logic [31:0] code_segment_word  = {24'h000000, code_segment_pointer};  // [RULE5] [RULE6]
	wire logic [31:0] configuration_word = {16'h0000, core_configuration_one};
	wire logic [31:0] status_word        = {31'h00000000, supervisor};
	wire logic [31:0] read_value =                                       // [RULE2]
		(s_axi_araddr == code_segment_offset)           ? code_segment_word :
		(s_axi_araddr == core_configuration_one_offset) ? configuration_word :
		(s_axi_araddr == core_status_offset)            ? status_word :
		                                                  32'h00000000;
	wire logic read_hit   = register_hit(s_axi_araddr);

	// Channel handshakes
	wire logic aw_take = s_axi_awvalid && s_axi_awready;
	wire logic w_take  = s_axi_wvalid && s_axi_wready;
	wire logic b_done  = s_axi_bvalid && s_axi_bready;
	wire logic ar_take = s_axi_arvalid && s_axi_arready;
	wire logic r_done  = s_axi_rvalid && s_axi_rready;

	// Segment register: reset takes a constant, vector segment copied on first enabled edge after release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			code_segment_pointer <= code_segment_reset[7:0];
			reset_seen           <= 1'b0;
		end
		else if (clock_enable)
		begin
			reset_seen <= 1'b1;
			code_segment_pointer <= reset_seen ? next_segment : vector_segment;  // [RULE7]
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			instruction_offset <= instruction_offset_reset;
		else if (clock_enable && reset_seen)
			instruction_offset <= next_offset;  // [RULE3]
	end

	// Supervisor ends for good at end of initialisation
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			supervisor <= 1'b1;
		else if (clock_enable && end_of_initialisation)
			supervisor <= 1'b0;  // [RULE20]
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			core_configuration_one <= core_configuration_one_reset;
		else if (clock_enable && write_cfg && supervisor)
			core_configuration_one <= next_config;  // [RULE20]
	end

	// Fetch address registered so the fetch path sees a clean value
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fetch_address <= 24'h000000;
		end
		else if (clock_enable)
		begin
			fetch_address <= next_fetch_address;  // [RULE1] [RULE4]
		end
	end

	// Controls lag a configuration write by one cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			core_controls <= '0;
		end
		else if (clock_enable)
		begin
			core_controls <= next_controls;  // [RULE14] [RULE17] [RULE18] [RULE19]
		end
	end

	// Disable instruction runs while supervisor or control bit set
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			watchdog_disable_execute <= 1'b0;
		end
		else if (clock_enable)
		begin
			watchdog_disable_execute <= next_disable_execute;  // [RULE15] [RULE16]
		end
	end

	// Enable instruction runs only with the control bit set
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			watchdog_enable_execute <= 1'b0;
		end
		else if (clock_enable)
		begin
			watchdog_enable_execute <= next_enable_execute;  // [RULE16]
		end
	end

	// Mode flag for the pipeline
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			segmentation_off <= 1'b0;
		end
		else if (clock_enable)
		begin
			segmentation_off <= ~segmented;  // [RULE8]
		end
	end

	// Write address ready pulses once per offer, never while an address is held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
		end
		else if (clock_enable)
		begin
			s_axi_awready <= !aw_held && s_axi_awvalid && !s_axi_awready;
		end
	end

	// Write channels are captured in either order, then answered together
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_addr <= 4'h0;
		end
		else if (clock_enable)
		begin
			if (aw_take)
				aw_addr <= {s_axi_awaddr[3:2], 2'b00};
			aw_held <= aw_take || (aw_held && !write_go);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_wready <= 1'b0;
		end
		else if (clock_enable)
		begin
			s_axi_wready <= !w_held && s_axi_wvalid && !s_axi_wready;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else if (clock_enable)
		begin
			if (w_take)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			w_held <= w_take || (w_held && !write_go);
		end
	end

	// Response waits for a free slot, so a slow master only stalls the next write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= resp_okay;
		end
		else if (clock_enable)
		begin
			if (write_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= write_hit ? resp_okay : resp_slverr;
			end
			else if (b_done)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read address is refused while a read answer still stands
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
		end
		else if (clock_enable)
		begin
			s_axi_arready <= read_go && !s_axi_arready;
		end
	end

	// Read data is taken from the address while it is still held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= resp_okay;
		end
		else if (clock_enable)
		begin
			if (ar_take)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= read_value;
				s_axi_rresp  <= read_hit ? resp_okay : resp_slverr;
			end
			else if (r_done)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule // code_address

// ---- verification/code_address_sva.sv ----
`timescale 1ns/1ns
module code_address_sva
	import code_address_pkg::*;
(
	// Watched ports, grouped to keep the checker short
	input wire logic              aclk, aresetn, clock_enable, segmentation_off, end_of_initialisation,
	input wire logic [7:0]        vector_segment,
	input wire flow_event_type    flow_event,
	input wire logic [23:0]       fetch_address,
	input wire core_controls_type core_controls,
	input wire logic              watchdog_disable_instruction, watchdog_enable_instruction,
	input wire logic              watchdog_disable_execute, watchdog_enable_execute
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [1:0] up;
	logic       ended;
	logic       go;
	// The first edges after reset belong to the segment capture, not to events
	always_ff @(posedge aclk)
	begin
		up    <= {up[0], aresetn};
		ended <= aresetn & (ended | end_of_initialisation);
	end
	assign go = up[1] & clock_enable;
	sequence far_flow;
		flow_event.kind inside {flow_far_jump, flow_far_call, flow_far_ret, flow_int_ret};
	endsequence
	a_far_loads: assert property (go && !segmentation_off ##0 far_flow |=>
		fetch_address == {$past(flow_event.segment), $past(flow_event.offset[15:1]), 1'b0})
		else $error("far flow address wrong");
	a_frozen_seg: assert property (go && segmentation_off ##0 far_flow |=> $stable(fetch_address[23:16]))
		else $error("segment moved in flat mode");
	a_vector_seg: assert property (go && flow_event.kind == flow_vector |=>
		fetch_address[23:16] == $past(vector_segment))
		else $error("vector did not load segment");
	a_seq_step: assert property (go && flow_event.kind == flow_sequence |=>
		fetch_address == {$past(fetch_address[23:16]), $past(fetch_address[15:0]) + 16'h0002})
		else $error("sequential step wrong");
	a_aligned_offset: assert property (fetch_address[0] == 1'b0)
		else $error("odd fetch offset");
	a_spacing_code: assert property (up[1] |-> core_controls.vector_spacing_words inside {5'h02, 5'h04, 5'h08, 5'h10})
		else $error("bad vector spacing");
	a_wd_enable: assert property (go && ended && $past(ended) && watchdog_enable_instruction |=>
		watchdog_enable_execute == $past(core_controls.watchdog_instructions_live))
		else $error("enable instruction gating wrong");
	a_wd_disable_nop: assert property (go && ended && watchdog_disable_instruction &&
		!core_controls.watchdog_instructions_live |=> !watchdog_disable_execute)
		else $error("disable instruction ran after init");
endmodule // code_address_sva

bind code_address code_address_sva i_code_address_sva (.aclk, .aresetn, .clock_enable, .segmentation_off,
	.end_of_initialisation, .vector_segment, .flow_event, .fetch_address, .core_controls,
	.watchdog_disable_instruction, .watchdog_enable_instruction, .watchdog_disable_execute, .watchdog_enable_execute);

// ---- verification/exec_model.sv ----
`timescale 1ns/1ns
module exec_model
	import code_address_pkg::*;
(
	// Clock
	input  wire logic      aclk,
	// Toward the block
	output flow_event_type flow_event,
	output logic [7:0]     vector_segment,
	output logic [2:0]     pulses
);
	initial
	begin
		flow_event     = '{flow_none, 8'h00, 16'h0000};
		vector_segment = 8'h5A;
		pulses         = 3'h0;
	end
	// One event for one cycle; idle payload is inverted so stale values never match
	task automatic step(input flow_event_type ev, input logic [2:0] p);
		@(posedge aclk);
		flow_event <= ev;
		pulses     <= p;
		@(posedge aclk);
		flow_event <= '{flow_none, ~ev.segment, ~ev.offset};
		pulses     <= 3'h0;
		#1;
	endtask
	// Vector table moved to the segment given by seg
	task automatic place_table(input logic [7:0] seg);
		@(posedge aclk);
		vector_segment <= seg;
	endtask
endmodule // exec_model

// ---- verification/tb_code_address.sv ----
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_code_address
	import code_address_pkg::*;
;
	logic              aclk = 1'b0, aresetn = 1'b0;
	flow_event_type    flow_event;
	logic [7:0]        vector_segment;
	logic [2:0]        pulses;
	logic [23:0]       fetch_address;
	core_controls_type core_controls;
	logic              watchdog_disable_execute, watchdog_enable_execute, segmentation_off;
	logic [3:0]        s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp, r;
	int                err_count = 0, tests_run = 0, cycles = 0, i;
	logic [6:0]        vals [4] = '{7'h00, 7'h27, 7'h45, 7'h72};

	exec_model i_exec_model (.aclk, .flow_event, .vector_segment, .pulses);
	code_address i_code_address (.clock_enable(1'b1), .end_of_initialisation(pulses[2]),
		.watchdog_enable_instruction(pulses[1]), .watchdog_disable_instruction(pulses[0]), .*);

	always #50 aclk = ~aclk;
	// Whole run needs about 110 cycles
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			err_count++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (1)
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (1)
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		{r, d} = {s_axi_rresp, s_axi_rdata};
	endtask

	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		#1;
		`CHK("reset address", 24'h5A0000, fetch_address)
		wr(code_segment_offset, 32'h000000FF);
		`CHK("segment write resp", resp_okay, r)
		rd(code_segment_offset);
		`CHK("segment", 32'h0000005A, d)
		rd(4'hC);
		`CHK("unmapped resp", resp_slverr, r)
		i_exec_model.step('{flow_sequence, 8'h00, 16'h0000}, 3'h0);
		`CHK("sequential", 24'h5A0002, fetch_address)
		i_exec_model.step('{flow_far_jump, 8'h12, 16'h3457}, 3'h0);
		`CHK("far jump", 24'h123456, fetch_address)
		for (i = 0; i < 3; i++)
		begin
			i_exec_model.step('{flow_kind_type'(3'(i + 4)), 8'(i + 8'h20), 16'h0100}, 3'h0);
			`CHK("far flow", {8'(i + 8'h20), 16'h0100}, fetch_address)
		end
		i_exec_model.step('{flow_near, 8'h77, 16'h0200}, 3'h0);
		`CHK("near branch", 24'h220200, fetch_address)
		i_exec_model.place_table(8'h33);
		i_exec_model.step('{flow_vector, 8'h77, 16'h0008}, 3'h0);
		`CHK("vector", 8'h33, fetch_address[23:16])
		wr(core_configuration_one_offset, 32'h00000008);
		`CHK("config write resp", resp_okay, r)
		rd(core_configuration_one_offset);
		`CHK("flat mode", 1'b1, segmentation_off)
		i_exec_model.step('{flow_far_jump, 8'h44, 16'h0000}, 3'h0);
		`CHK("frozen", 8'h33, fetch_address[23:16])
		i_exec_model.place_table(8'h35);
		i_exec_model.step('{flow_vector, 8'h77, 16'h0010}, 3'h0);
		`CHK("flat vector", 8'h35, fetch_address[23:16])
		for (i = 0; i < 4; i++)
		begin
			wr(core_configuration_one_offset, {25'h0, vals[i]});
			rd(core_configuration_one_offset);
			`CHK("config", {25'h0, vals[i]}, d)
			`CHK("spacing", 5'h02 << vals[i][6:5], core_controls.vector_spacing_words)
			`CHK("enables", vals[i][2:0], {core_controls.context_switch_interruptible,
				core_controls.branch_prediction_enable, core_controls.zero_cycle_jump_enable})
		end
		i_exec_model.step('{flow_none, 8'h00, 16'h0000}, 3'h3);
		`CHK("watchdog live", 2'h3, {watchdog_enable_execute, watchdog_disable_execute})
		wr(core_configuration_one_offset, 32'h00000000);
		rd(core_configuration_one_offset);
		i_exec_model.step('{flow_none, 8'h00, 16'h0000}, 3'h3);
		`CHK("watchdog init", 2'h1, {watchdog_enable_execute, watchdog_disable_execute})
		i_exec_model.step('{flow_none, 8'h00, 16'h0000}, 3'h4);
		i_exec_model.step('{flow_none, 8'h00, 16'h0000}, 3'h3);
		`CHK("watchdog nop", 2'h0, {watchdog_enable_execute, watchdog_disable_execute})
		wr(core_configuration_one_offset, 32'h00000010);
		rd(core_configuration_one_offset);
		`CHK("locked config", 32'h00000000, d)
		conclude();
	end
endmodule // tb_code_address
